// file: hw/cvic_pkg.sv
// Shared constants and carrier types for the cascaded vectored interrupt controller
package cvic_pkg;

   // Shape of one channel
   localparam int NSRC = 32;
   localparam int SRCW = 5;
   localparam int LVLW = 4;
   localparam int TBRW = 24;
   localparam int VECW = 32;

   // Fixed source slots on the first channel
   localparam logic [SRCW-1:0] CASCADE_SRC = 5'h06;
   localparam logic [SRCW-1:0] DELAY_SRC = 5'h1e;

   // Low byte of a vector is this correction plus four times the source
   localparam logic [7:0] VEC_CORR = 8'h20;

   // Fixed core exception vectors (low vector map)
   localparam logic [31:0] CORE_IRQ_VEC = 32'h0000_0018;
   localparam logic [31:0] CORE_FIQ_VEC = 32'h0000_001c;

   // Sources that have a requester; all others are tied inactive
   localparam logic [NSRC-1:0] CH0_USED = 32'h73ff_ffc0;
   localparam logic [NSRC-1:0] CH1_USED = 32'h1d07_fbfd;

   // Reset values of the block's own state
   localparam logic FLAG_RESET = 1'b0;
   localparam logic [SRCW-1:0] SRC_RESET = 5'h00;
   localparam logic [LVLW-1:0] LVL_RESET = 4'hf;
   localparam logic [VECW-1:0] VEC_RESET = 32'h0000_0000;

   // Software view of one channel's settings
   typedef struct packed {
      logic [NSRC-1:0] enable;
      logic [NSRC*LVLW-1:0] levels;
      logic [LVLW-1:0] level_mask;
      logic [TBRW-1:0] table_base;
   } cvic_chan_cfg_t;

   // What one channel presents to the core and to software
   typedef struct packed {
      logic irq;
      logic [SRCW-1:0] src;
      logic [LVLW-1:0] level;
      logic [VECW-1:0] vector;
   } cvic_chan_stat_t;

endpackage

// file: hw/cvic_channel.sv
// One 32-source prioritising channel with vector generation
module cvic_channel #(
   parameter int NSRC = 32,
   parameter int LVLW = 4,
   parameter logic [31:0] USED = 32'hffff_ffff
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [NSRC-1:0] req,
   input wire cvic_pkg::cvic_chan_cfg_t cfg,
   output cvic_pkg::cvic_chan_stat_t stat,
   output logic pending
);

   // Field widths are fixed by the package carrier types; refuse any other shape
   if (NSRC != cvic_pkg::NSRC || LVLW != cvic_pkg::LVLW) begin : g_bad_geometry
      $error("cvic_channel: geometry must match the package");
   end

   logic [NSRC-1:0] elig;
   logic [LVLW-1:0] lvl_of [NSRC];
   logic best_found;
   logic [LVLW-1:0] best_lvl;
   logic [cvic_pkg::SRCW-1:0] best_src;
   cvic_pkg::cvic_chan_stat_t stat_reg;
   cvic_pkg::cvic_chan_stat_t stat_next;

   // Per-source eligibility: requested, enabled, and a real source
   genvar g;
   generate
      for (g = 0; g < NSRC; g++) begin : g_src
         assign elig[g] = req[g] & cfg.enable[g] & USED[g];
         assign lvl_of[g] = cfg.levels[g*LVLW +: LVLW];
      end
   endgenerate

   // Lower level value wins; strict compare keeps the lowest index on ties
   always_comb begin
      best_found = 1'b0;
      best_lvl = cvic_pkg::LVL_RESET;
      best_src = cvic_pkg::SRC_RESET;
      for (int i = 0; i < NSRC; i++) begin
         if (elig[i] && (!best_found || lvl_of[i] < best_lvl)) begin
            best_found = 1'b1;
            best_lvl = lvl_of[i];
            best_src = cvic_pkg::SRCW'(i);
         end
      end
   end

   // Only levels below the core mask get through to the IRQ line
   assign stat_next.irq = best_found && (best_lvl < cfg.level_mask);
   assign stat_next.src = best_src;
   assign stat_next.level = best_lvl;
   // Vector is base in the upper bits, correction plus 4*source below
   assign stat_next.vector = {cfg.table_base,
                              cvic_pkg::VEC_CORR + {1'b0, best_src, 2'b00}};
   assign pending = |elig;

   // Source, level and vector only move while a winner passes the level mask, so software sees the last one
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         stat_reg <= '{irq: cvic_pkg::FLAG_RESET, src: cvic_pkg::SRC_RESET,
                       level: cvic_pkg::LVL_RESET, vector: cvic_pkg::VEC_RESET};
      end else if (stat_next.irq) begin
         stat_reg <= stat_next;
      end else begin
         stat_reg.irq <= 1'b0;
      end
   end

   assign stat = stat_reg;

endmodule // cvic_channel

// file: hw/cvic_top.sv
// Cascaded vectored interrupt controller: two channels, delay and FIQ paths, wake-up
module cvic_top (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [cvic_pkg::NSRC-1:0] ch0_req,
   input wire logic [cvic_pkg::NSRC-1:0] ch1_req,
   input wire cvic_pkg::cvic_chan_cfg_t ch0_cfg,
   input wire cvic_pkg::cvic_chan_cfg_t ch1_cfg,
   input wire logic delay_set,
   input wire logic delay_clear,
   input wire logic soft_fiq_set,
   input wire logic soft_fiq_clear,
   input wire logic fiq_pin,
   output logic irq_to_core,
   output logic fiq_to_core,
   output cvic_pkg::cvic_chan_stat_t ch0_stat,
   output cvic_pkg::cvic_chan_stat_t ch1_stat,
   output logic delay_pending,
   output logic soft_fiq_pending,
   output logic wake_to_crg
);

   logic delay_reg;
   logic delay_next;
   logic soft_fiq_reg;
   logic soft_fiq_next;
   logic fiq_meta_reg;
   logic fiq_sync_reg;
   logic fiq_reg;
   logic wake_reg;
   logic ch0_pending;
   logic ch1_pending;
   logic [cvic_pkg::NSRC-1:0] ch0_eff_req;
   logic [cvic_pkg::NSRC-1:0] ch1_eff_req;
   logic [cvic_pkg::NSRC-1:0] slot_cascade;
   logic [cvic_pkg::NSRC-1:0] slot_delay;

   // Software strobes: a set in the same cycle as a clear wins
   assign delay_next = delay_set | (delay_reg & ~delay_clear);
   assign soft_fiq_next = soft_fiq_set | (soft_fiq_reg & ~soft_fiq_clear);

   // Delay interrupt and software FIQ latches; all state runs on the bus clock
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         delay_reg <= cvic_pkg::FLAG_RESET;
         soft_fiq_reg <= cvic_pkg::FLAG_RESET;
      end else begin
         delay_reg <= delay_next;
         soft_fiq_reg <= soft_fiq_next;
      end
   end

   // FIQ pin comes from outside; two stages before anything looks at it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fiq_meta_reg <= cvic_pkg::FLAG_RESET;
         fiq_sync_reg <= cvic_pkg::FLAG_RESET;
      end else begin
         fiq_meta_reg <= fiq_pin;
         fiq_sync_reg <= fiq_meta_reg;
      end
   end

   // One-hot slot masks for the internally driven sources
   assign slot_cascade = cvic_pkg::NSRC'(1) << cvic_pkg::CASCADE_SRC;
   assign slot_delay = cvic_pkg::NSRC'(1) << cvic_pkg::DELAY_SRC;

   // Second channel only sees its mapped peripherals
   assign ch1_eff_req = ch1_req & cvic_pkg::CH1_USED;

   // First channel: peripherals, cascade on slot 6, delay circuit on slot 30.
   // The external pins on those two slots are ignored so nothing can fake them.
   assign ch0_eff_req = (ch0_req & cvic_pkg::CH0_USED & ~slot_cascade & ~slot_delay)
                        | (ch1_stat.irq ? slot_cascade : '0)
                        | (delay_reg ? slot_delay : '0);

   // Second channel; its IRQ never reaches the core directly
   cvic_channel #(
      .NSRC(cvic_pkg::NSRC),
      .LVLW(cvic_pkg::LVLW),
      .USED(cvic_pkg::CH1_USED)
   ) u_ch1 (
      .sys_clk(sys_clk),
      .rst(rst),
      .req(ch1_eff_req),
      .cfg(ch1_cfg),
      .stat(ch1_stat),
      .pending(ch1_pending)
   );

   // First channel, whose IRQ is the one the core sees
   cvic_channel #(
      .NSRC(cvic_pkg::NSRC),
      .LVLW(cvic_pkg::LVLW),
      .USED(cvic_pkg::CH0_USED)
   ) u_ch0 (
      .sys_clk(sys_clk),
      .rst(rst),
      .req(ch0_eff_req),
      .cfg(ch0_cfg),
      .stat(ch0_stat),
      .pending(ch0_pending)
   );

   // FIQ and wake-up are registered so the core and clock generator see clean levels.
   // Wake ignores the level mask: a sleeping system must come back for any enabled source.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fiq_reg <= cvic_pkg::FLAG_RESET;
         wake_reg <= cvic_pkg::FLAG_RESET;
      end else begin
         fiq_reg <= fiq_sync_reg | soft_fiq_reg;
         wake_reg <= ch0_pending | ch1_pending | fiq_sync_reg | soft_fiq_reg;
      end
   end

   // Core lines: IRQ vectors via the extended table, FIQ via its fixed slot
   assign irq_to_core = ch0_stat.irq;
   assign fiq_to_core = fiq_reg;
   assign delay_pending = delay_reg;
   assign soft_fiq_pending = soft_fiq_reg;
   assign wake_to_crg = wake_reg;

endmodule // cvic_top

// file: tb/cvic_monitor.sv
// Port checker for the cascaded interrupt controller
module cvic_monitor (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [cvic_pkg::NSRC-1:0] ch0_req,
   input wire cvic_pkg::cvic_chan_cfg_t ch0_cfg,
   input wire logic delay_set,
   input wire logic soft_fiq_set,
   input wire logic fiq_to_core,
   input wire cvic_pkg::cvic_chan_stat_t ch0_stat,
   input wire cvic_pkg::cvic_chan_stat_t ch1_stat,
   input wire logic delay_pending,
   input wire logic soft_fiq_pending,
   input wire logic wake_to_crg
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Bits 6 and 30 are fed from inside, so their pins never count
   wire logic [31:0] live0 = ch0_req & ch0_cfg.enable & cvic_pkg::CH0_USED & 32'hbfff_ffbf;
   AST_VEC_LOW: assert property (ch0_stat.irq |-> ch0_stat.vector[7:0] == 8'h20 + {ch0_stat.src, 2'b00})
      else $error("vector offset wrong");
   AST_VEC_BASE: assert property (ch0_stat.irq |-> ch0_stat.vector[31:8] == $past(ch0_cfg.table_base))
      else $error("vector base wrong");
   AST_GATE: assert property (ch0_stat.irq |-> ch0_stat.level < $past(ch0_cfg.level_mask))
      else $error("level not below mask");
   AST_CASCADE: assert property (ch1_stat.irq && ch0_cfg.enable[6] && ch0_cfg.levels[27:24] < ch0_cfg.level_mask |=> ch0_stat.irq)
      else $error("cascade lost");
   AST_QUIET: assert property (live0 == 32'h0 && !ch1_stat.irq && !delay_pending |=> !ch0_stat.irq)
      else $error("irq without source");
   AST_WAKE: assert property (live0 != 32'h0 |=> wake_to_crg)
      else $error("no wake");
   AST_SOFT: assert property (soft_fiq_set |=> soft_fiq_pending ##1 fiq_to_core)
      else $error("soft fiq lost");
   AST_DELAY: assert property (delay_set |=> delay_pending)
      else $error("delay not pending");
endmodule // cvic_monitor

// file: tb/cvic_core_model.sv
// Core model: dispatches through the vector readout and counts FIQ entries
module cvic_core_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic irq,
   input wire logic fiq,
   input wire logic [31:0] vector,
   output logic [31:0] target,
   output logic [7:0] fiq_hits
);
   timeunit 1ns;
   timeprecision 1ps;
   logic irq_reg, fiq_reg;
   // Entry on a rising request; the fixed slot alone would lose the source
   always_ff @(posedge sys_clk) begin
      irq_reg <= irq & ~rst;
      fiq_reg <= fiq & ~rst;
      if (rst) begin
         target <= 32'h0;
         fiq_hits <= 8'h0;
      end else begin
         if (irq && !irq_reg) target <= vector;
         if (fiq && !fiq_reg) fiq_hits <= fiq_hits + 8'h1;
      end
   end
endmodule // cvic_core_model

// file: tb/cvic_bench.sv
// Self-checking bench for the cascaded interrupt controller
module cvic_bench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [31:0] r0; logic [31:0] r1; logic irq; logic [4:0] src;} cvic_row_t;
   logic sys_clk = 1'b0, rst = 1'b1, dset = 1'b0, dclr = 1'b0, fset = 1'b0, fclr = 1'b0;
   logic fpin = 1'b0, irq, fiq, dpend, fpend, wake;
   logic [31:0] r0 = 32'h0, r1 = 32'h0, target;
   logic [7:0] hits;
   cvic_pkg::cvic_chan_cfg_t c0, c1;
   cvic_pkg::cvic_chan_stat_t s0, s1;
   int n_errors = 0, comparisons = 0, cyc = 0;
   // Tie, priority, disabled, unused, cascade, pin-ignored rows
   cvic_row_t rows [7] = '{'{32'h0000_1080, 32'h0, 1'b1, 5'h07}, '{32'h0000_1200, 32'h0, 1'b1, 5'h09},
      '{32'h0010_0000, 32'h0, 1'b0, 5'h00}, '{32'h0400_0001, 32'h0, 1'b0, 5'h00},
      '{32'h0, 32'h0000_0010, 1'b1, 5'h06}, '{32'h0000_0200, 32'h0000_0010, 1'b1, 5'h09},
      '{32'h8000_0040, 32'h0, 1'b0, 5'h00}};
   cvic_top i_dut (.sys_clk, .rst, .ch0_req(r0), .ch1_req(r1), .ch0_cfg(c0), .ch1_cfg(c1),
      .delay_set(dset), .delay_clear(dclr), .soft_fiq_set(fset), .soft_fiq_clear(fclr),
      .fiq_pin(fpin), .irq_to_core(irq), .fiq_to_core(fiq), .ch0_stat(s0), .ch1_stat(s1),
      .delay_pending(dpend), .soft_fiq_pending(fpend), .wake_to_crg(wake));
   cvic_core_model u_core (.sys_clk, .rst, .irq, .fiq, .vector(s0.vector), .target,
      .fiq_hits(hits));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
         n_errors++;
      end
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Clock and a hang limit well above the expected run of about 50 cycles
   initial forever #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 400) begin
         n_errors++;
         final_report();
      end
   end
   // Inputs move on falling edges only
   initial begin
      c0 = '{32'hffef_ffff, {32{4'h5}}, 4'h8, 24'h12_3456};
      c0.levels[39:36] = 4'h2;
      c0.levels[27:24] = 4'h3;
      c1 = '{32'hffff_ffff, {32{4'h5}}, 4'h8, 24'h00_0001};
      c1.levels[19:16] = 4'h1;
      repeat (3) @(negedge sys_clk);
      check(s0.level, 4'hf);
      check(irq, 1'b0);
      check(s0.vector, 32'h0);
      rst = 1'b0;
      for (int i = 0; i < 7; i++) begin
         r0 = rows[i].r0;
         r1 = rows[i].r1;
         repeat (3) @(negedge sys_clk);
         check(irq, rows[i].irq);
         if (rows[i].irq) begin
            check(s0.src, rows[i].src);
            check(s0.level, c0.levels[4*rows[i].src +: 4]);
            check(s0.vector, {24'h12_3456, 8'h20 + {rows[i].src, 2'b00}});
         end
         if (r1 != 32'h0) begin
            check(s1.vector, 32'h0000_0130);
            check(s1.src, 5'h04);
            check(s1.level, c1.levels[19:16]);
         end
         $display("row %0d done", i);
      end
      // Delay source raised and cleared by strobes alone
      dset = 1'b1;
      @(negedge sys_clk) dset = 1'b0;
      @(negedge sys_clk);
      check(irq, 1'b1);
      check(s0.vector, 32'h1234_5698);
      dclr = 1'b1;
      @(negedge sys_clk) dclr = 1'b0;
      repeat (2) @(negedge sys_clk);
      check(irq, 1'b0);
      check(target, 32'h1234_5698);
      // Set and clear in one cycle: the set must win, a lone clear then drops it
      dset = 1'b1;
      dclr = 1'b1;
      @(negedge sys_clk) dset = 1'b0;
      check(dpend, 1'b1);
      @(negedge sys_clk) dclr = 1'b0;
      check(dpend, 1'b0);
      // Software FIQ, then the pin path
      fset = 1'b1;
      @(negedge sys_clk) fset = 1'b0;
      @(negedge sys_clk);
      check(fiq, 1'b1);
      check(fpend, 1'b1);
      fclr = 1'b1;
      @(negedge sys_clk) fclr = 1'b0;
      fpin = 1'b1;
      repeat (3) @(negedge sys_clk);
      check(fiq, 1'b1);
      fpin = 1'b0;
      repeat (4) @(negedge sys_clk);
      check({fiq, hits}, 9'h002);
      // Strict mask boundary; wake ignores the mask
      r0 = 32'h0000_0200;
      c0.level_mask = 4'h2;
      repeat (3) @(negedge sys_clk);
      check({irq, wake}, 2'b01);
      c0.level_mask = 4'h3;
      repeat (2) @(negedge sys_clk);
      check(irq, 1'b1);
      // Reset in mid-run with an interrupt standing, then recovery
      rst = 1'b1;
      @(negedge sys_clk) rst = 1'b0;
      check(irq, 1'b0);
      check(s0.level, cvic_pkg::LVL_RESET);
      check(s0.vector, cvic_pkg::VEC_RESET);
      check(wake, 1'b0);
      @(negedge sys_clk);
      check(irq, 1'b1);
      check(wake, 1'b1);
      $display("hand tests done");
      final_report();
   end
endmodule // cvic_bench
bind cvic_top cvic_monitor i_mon (.sys_clk, .rst, .ch0_req, .ch0_cfg, .delay_set,
   .soft_fiq_set, .fiq_to_core, .ch0_stat, .ch1_stat, .delay_pending, .soft_fiq_pending,
   .wake_to_crg);
